// ==== sleep_ctrl.sv ====
// module: sleep mode controller with clock gating and ahb-lite registers
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module sleep_ctrl #(
  parameter int STARTUP_CYCLES = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // cpu side
  input wire logic sleep_instr_i,
  input wire logic any_reset_i,
  output logic cpu_hold_o,
  output logic resume_irq_o,
  output logic restart_vector_o,
  // fuses and converter
  input wire logic crystal_option_i,
  input wire logic [15:0] clock_source_fuses_delay_i,
  input wire logic converter_enabled_i,
  output logic conv_start_o,
  // wake sources, already synchronised by the interrupt logic
  input wire logic [sleep_pkg::WS_WIDTH-1:0] wake_src_i,
  input wire logic irq_pending_i,
  // clock domain enables
  output logic cpu_clock_domain_en_o,
  output logic flash_clock_domain_en_o,
  output logic io_clock_domain_en_o,
  output logic converter_clock_domain_en_o,
  output logic oscillator_en_o
);
  logic [7:0] ctrl_q;
  logic [2:0] mode_q;
  logic [2:0] halt_cnt_q;
  logic wake_irq_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic conv_q;
  logic [31:0] rdata_q;
  sleep_pkg::sleep_state_e state_q;
  wake_if w ();
  logic sleep_arm_bit;
  logic [2:0] sleep_mode_select;
  logic mode_valid;
  logic wake_hit;
  logic addr_phase;

  // legal mode check; standby also needs a crystal option
  function automatic logic mode_ok(input logic [2:0] m, input logic xtal);
    case (m)
      sleep_pkg::MODE_IDLE,
      sleep_pkg::MODE_NOISE,
      sleep_pkg::MODE_PDOWN: mode_ok = 1'b1;
      sleep_pkg::MODE_STANDBY: mode_ok = xtal;
      default: mode_ok = 1'b0;
    endcase
  endfunction : mode_ok

  assign sleep_arm_bit = ctrl_q[sleep_pkg::ARM_BIT];
  assign sleep_mode_select = ctrl_q[sleep_pkg::MODE_MSB:sleep_pkg::MODE_LSB];
  assign mode_valid = mode_ok(sleep_mode_select, crystal_option_i);

  // mode-specific wake sources
  always_comb begin
    case (mode_q)
      sleep_pkg::MODE_IDLE: wake_hit = irq_pending_i;
      sleep_pkg::MODE_NOISE: wake_hit = wake_src_i[sleep_pkg::WS_CONV_DONE]
        | wake_src_i[sleep_pkg::WS_TIMER] | wake_src_i[sleep_pkg::WS_NVM_READY]
        | wake_src_i[sleep_pkg::WS_EXT_LEVEL];
      sleep_pkg::MODE_PDOWN,
      sleep_pkg::MODE_STANDBY: wake_hit = wake_src_i[sleep_pkg::WS_PSC]
        | wake_src_i[sleep_pkg::WS_EXT_LEVEL];
      default: wake_hit = 1'b0;
    endcase
  end

  // ahb-lite address phase capture; writes land in the data phase
  assign addr_phase = hsel_i && hready_i && htrans_i[1];
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase && hwrite_i;
      if (addr_phase) wr_addr_q <= haddr_i;
    end
  end

  // read data registered at the address phase, zero for unmapped
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_phase && !hwrite_i) begin
      case (haddr_i)
        sleep_pkg::SLEEP_CTRL_OFS: rdata_q <= {24'h000000, ctrl_q};
        sleep_pkg::SLEEP_STAT_OFS: rdata_q <= {29'h0, state_q};
        sleep_pkg::CONV_CTRL_OFS: rdata_q <= {31'h0, conv_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign hrdata_o = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // control register: upper nibble never stored so it reads zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q <= sleep_pkg::CTRL_RESET;
    end else if (wr_pend_q && wr_addr_q == sleep_pkg::SLEEP_CTRL_OFS) begin
      ctrl_q <= hwdata_i[7:0] & sleep_pkg::CTRL_WMASK;
    end
  end

  // sleep sequencer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= sleep_pkg::ST_RUN;
      mode_q <= sleep_pkg::MODE_IDLE;
      wake_irq_q <= 1'b0;
      halt_cnt_q <= 3'h0;
    end else if (any_reset_i) begin
      state_q <= sleep_pkg::ST_RUN;
      wake_irq_q <= 1'b0;
    end else begin
      case (state_q)
        sleep_pkg::ST_RUN: begin
          // unarmed or reserved code: instruction falls through
          if (sleep_instr_i && sleep_arm_bit && mode_valid) begin
            state_q <= sleep_pkg::ST_SLEEP;
            mode_q <= sleep_mode_select;
          end
        end
        sleep_pkg::ST_SLEEP: begin
          if (wake_hit) begin
            wake_irq_q <= 1'b1;
            if (mode_q == sleep_pkg::MODE_IDLE || mode_q == sleep_pkg::MODE_NOISE) begin
              state_q <= sleep_pkg::ST_HALT;
              halt_cnt_q <= 3'(sleep_pkg::IRQ_HALT_CYCLES);
            end else begin
              state_q <= sleep_pkg::ST_STARTUP;
            end
          end
        end
        sleep_pkg::ST_STARTUP: begin
          if (w.done) begin
            state_q <= sleep_pkg::ST_HALT;
            halt_cnt_q <= 3'(sleep_pkg::IRQ_HALT_CYCLES);
          end
        end
        sleep_pkg::ST_HALT: begin
          halt_cnt_q <= halt_cnt_q - 3'h1;
          if (halt_cnt_q == 3'h1) begin
            state_q <= sleep_pkg::ST_RUN;
            wake_irq_q <= 1'b0;
          end
        end
        default: state_q <= sleep_pkg::ST_RUN;
      endcase
    end
  end

  // start-up delay: fixed six for standby, fuse value for power-down, or STARTUP_CYCLES when the fuses read zero
  assign w.start = (state_q == sleep_pkg::ST_SLEEP) && wake_hit
    && (mode_q == sleep_pkg::MODE_PDOWN || mode_q == sleep_pkg::MODE_STANDBY);
  assign w.count = (mode_q == sleep_pkg::MODE_STANDBY)
    ? 16'(sleep_pkg::STANDBY_WAKE_CYCLES)
    : ((clock_source_fuses_delay_i == 16'h0000) ? 16'(STARTUP_CYCLES)
      : clock_source_fuses_delay_i);

  wake_timer u_timer (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .w(w)
  );

  // one conversion kick on entry to idle or noise with converter on
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      conv_q <= 1'b0;
    end else begin
      conv_q <= (state_q == sleep_pkg::ST_RUN) && sleep_instr_i && sleep_arm_bit
        && converter_enabled_i && (sleep_mode_select == sleep_pkg::MODE_IDLE
        || sleep_mode_select == sleep_pkg::MODE_NOISE) && !any_reset_i;
    end
  end
  assign conv_start_o = conv_q;

  // clock domain gating per mode; memories only lose their clock, not data
  always_comb begin
    cpu_clock_domain_en_o = 1'b1;
    flash_clock_domain_en_o = 1'b1;
    io_clock_domain_en_o = 1'b1;
    converter_clock_domain_en_o = 1'b1;
    oscillator_en_o = 1'b1;
    if (state_q == sleep_pkg::ST_SLEEP || state_q == sleep_pkg::ST_STARTUP) begin
      cpu_clock_domain_en_o = 1'b0;
      flash_clock_domain_en_o = 1'b0;
      case (mode_q)
        sleep_pkg::MODE_NOISE: io_clock_domain_en_o = 1'b0;
        sleep_pkg::MODE_PDOWN: begin
          io_clock_domain_en_o = 1'b0;
          converter_clock_domain_en_o = 1'b0;
          oscillator_en_o = (state_q == sleep_pkg::ST_STARTUP);
        end
        sleep_pkg::MODE_STANDBY: begin
          io_clock_domain_en_o = 1'b0;
          converter_clock_domain_en_o = 1'b0;
        end
        default: io_clock_domain_en_o = 1'b1;
      endcase
    end
  end

  assign cpu_hold_o = (state_q != sleep_pkg::ST_RUN);
  assign resume_irq_o = (state_q == sleep_pkg::ST_HALT) && (halt_cnt_q == 3'h1) && wake_irq_q;
  assign restart_vector_o = (state_q != sleep_pkg::ST_RUN) && any_reset_i;
endmodule : sleep_ctrl
`default_nettype wire

// ==== sleep_pkg.sv ====
// package: sleep controller register map, mode codes and timing constants
package sleep_pkg;
  // register byte offsets on the ahb-lite bus
  localparam logic [7:0] SLEEP_CTRL_OFS = 8'h00;
  localparam logic [7:0] SLEEP_STAT_OFS = 8'h04;
  localparam logic [7:0] CONV_CTRL_OFS = 8'h08;
  // control field layout
  localparam int ARM_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h0F;
  // sleep mode codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_NOISE = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  // wake timing in clock cycles
  localparam int IRQ_HALT_CYCLES = 4;
  localparam int STANDBY_WAKE_CYCLES = 6;
  // wake source vector positions
  localparam int WS_EXT_LEVEL = 0;
  localparam int WS_CONV_DONE = 1;
  localparam int WS_TIMER = 2;
  localparam int WS_NVM_READY = 3;
  localparam int WS_PSC = 4;
  localparam int WS_OTHER_IO = 5;
  localparam int WS_WIDTH = 6;
  typedef enum logic [2:0] {
    ST_RUN, ST_SLEEP, ST_STARTUP, ST_HALT
  } sleep_state_e;
endpackage : sleep_pkg

// ==== wake_if.sv ====
// interface: wake request and delay counter handshake
`timescale 1ns/1ps
`default_nettype none
interface wake_if;
  logic start;
  logic [15:0] count;
  logic done;
  modport ctl (output start, output count, input done);
  modport tmr (input start, input count, output done);
endinterface : wake_if
`default_nettype wire

// ==== wake_timer.sv ====
// module: down counter timing wake-up delays
`timescale 1ns/1ps
`default_nettype none
module wake_timer (
  input wire logic clk_i,
  input wire logic srst_i,
  wake_if.tmr w
);
  logic [15:0] cnt_q;
  logic busy_q;
  // load on start, count down, pulse done when the count reaches one
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= 16'h0000;
      busy_q <= 1'b0;
    end else if (w.start) begin
      cnt_q <= w.count;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= 16'h0001) busy_q <= 1'b0;
      cnt_q <= cnt_q - 16'h0001;
    end
  end
  assign w.done = busy_q && (cnt_q <= 16'h0001);
endmodule : wake_timer
`default_nettype wire

// ==== sleep_ctrl_props.sv ====
// checker: clock gating and wake timing relations at the controller ports
`timescale 1ns/1ps
`default_nettype none
module sleep_ctrl_props (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic any_reset_i,
  input wire logic converter_enabled_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic cpu_hold_o,
  input wire logic resume_irq_o,
  input wire logic conv_start_o,
  input wire logic cpu_clock_domain_en_o,
  input wire logic flash_clock_domain_en_o,
  input wire logic io_clock_domain_en_o,
  input wire logic converter_clock_domain_en_o,
  input wire logic oscillator_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_cpu_flash; cpu_clock_domain_en_o == flash_clock_domain_en_o; endproperty
  a_cpu_flash: assert property (p_cpu_flash) else $error("cpu and flash enables differ");
  property p_io_cpu; !io_clock_domain_en_o |-> !cpu_clock_domain_en_o; endproperty
  a_io_cpu: assert property (p_io_cpu) else $error("cpu clock runs without io clock");
  property p_osc; !oscillator_en_o |-> !io_clock_domain_en_o && !converter_clock_domain_en_o;
  endproperty
  a_osc: assert property (p_osc) else $error("clock runs with oscillator off");
  property p_resume; resume_irq_o |-> cpu_hold_o && $past(cpu_hold_o, 3) ##1 !cpu_hold_o;
  endproperty
  a_resume: assert property (p_resume) else $error("resume pulse not after halt");
  property p_rst_wake; any_reset_i && cpu_hold_o |=> !cpu_hold_o; endproperty
  a_rst_wake: assert property (p_rst_wake) else $error("reset did not wake");
  property p_conv; conv_start_o |-> $past(converter_enabled_i) ##1 !conv_start_o; endproperty
  a_conv: assert property (p_conv) else $error("bad conversion start");
  property p_rst_vals; $past(srst_i) |-> hrdata_o == 32'h0 && !cpu_hold_o && oscillator_en_o;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad state after reset");
  property p_bus; hreadyout_o && !hresp_o; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or error");
endmodule : sleep_ctrl_props
`default_nettype wire

// ==== wake_agent.sv ====
// wake source model: raises interrupt and wake levels and holds them while asleep
`timescale 1ns/1ps
`default_nettype none
module wake_agent (
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic go_i,
  input wire logic [6:0] sel_i,
  output logic [5:0] src_o,
  output logic irq_o
);
  // levels stay up until the cpu runs, so a slow wake path still sees them
  always_ff @(posedge clk_i) begin
    if (!hold_i) {irq_o, src_o} <= 7'h00;
    else if (go_i) {irq_o, src_o} <= {irq_o, src_o} | sel_i;
  end
endmodule : wake_agent
`default_nettype wire

// ==== sleep_ctrl_test.sv ====
// testbench: register access, every sleep mode, wake timing and reset while asleep
`timescale 1ns/1ps
`default_nettype none
module sleep_ctrl_test;
  localparam int STARTUP = 4;
  logic clk_i = 1'b0, srst_i = 1'b1, hsel = 1'b0, hwrite = 1'b0, sleep_instr = 1'b0;
  logic any_reset = 1'b0;
  logic hready, hresp, hold, resume, restart_vec, conv_start, crystal = 1'b1, conv_en = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [15:0] fuse = 16'h0;
  logic [5:0] wsrc;
  // five separate port drivers, so a net rather than a variable
  wire logic [4:0] en;
  logic [6:0] sel = 7'h00;
  logic irq, go = 1'b0;
  int fails = 0, n_compared = 0;
  sleep_ctrl #(.STARTUP_CYCLES(STARTUP)) i_sleep_ctrl (.clk_i(clk_i), .srst_i(srst_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .sleep_instr_i(sleep_instr), .any_reset_i(any_reset), .cpu_hold_o(hold),
    .resume_irq_o(resume), .restart_vector_o(restart_vec), .crystal_option_i(crystal),
    .clock_source_fuses_delay_i(fuse), .converter_enabled_i(conv_en), .conv_start_o(conv_start),
    .wake_src_i(wsrc), .irq_pending_i(irq), .cpu_clock_domain_en_o(en[4]),
    .flash_clock_domain_en_o(en[3]), .io_clock_domain_en_o(en[2]),
    .converter_clock_domain_en_o(en[1]), .oscillator_en_o(en[0]));
  wake_agent i_wake_agent (.clk_i(clk_i), .hold_i(hold), .go_i(go), .sel_i(sel), .src_o(wsrc),
    .irq_o(irq));
  // free running system clock
  initial forever #4 clk_i = ~clk_i;
  task automatic conclude;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // bounded wait for the slave, a hang counts as a mismatch
  task automatic rdy;
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (hready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      conclude();
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask : bus
  // arm just before the sleep instruction, upper data bits random
  task automatic do_sleep(input logic [2:0] m, input logic arm, input logic xtal);
    @(posedge clk_i);
    crystal <= xtal;
    fuse <= 16'($urandom_range(0, 9));
    conv_en <= 1'($urandom);
    bus(1'b1, sleep_pkg::SLEEP_CTRL_OFS, ($urandom & 32'hFFFFFFF0) | {m, arm});
    sleep_instr <= 1'b1;
    @(posedge clk_i);
    sleep_instr <= 1'b0;
    #1;
    chk("conv start", 32'(arm && conv_en && m inside {3'h0, 3'h1}), conv_start);
  endtask : do_sleep
  task automatic poke(input logic [6:0] s);
    @(posedge clk_i);
    go <= 1'b1;
    sel <= s;
    @(posedge clk_i);
    go <= 1'b0;
  endtask : poke
  function automatic logic [4:0] ens(input logic [2:0] m);
    case (m)
      sleep_pkg::MODE_IDLE: return 5'h07;
      sleep_pkg::MODE_NOISE: return 5'h03;
      sleep_pkg::MODE_STANDBY: return 5'h01;
      default: return 5'h00;
    endcase
  endfunction : ens
  // cycles from wake level to running: delay, then the halt cycles
  function automatic int wait_len(input logic [2:0] m, input logic [15:0] f);
    int d = 0;
    if (m == sleep_pkg::MODE_PDOWN) d = (f == 16'h0) ? STARTUP : int'(f);
    if (m == sleep_pkg::MODE_STANDBY) d = sleep_pkg::STANDBY_WAKE_CYCLES;
    return d + sleep_pkg::IRQ_HALT_CYCLES + 1;
  endfunction : wait_len
  initial begin
    int n, pulses;
    logic [2:0] m;
    void'($urandom(32'h8dce36da));
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    bus(1'b0, sleep_pkg::SLEEP_CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    bus(1'b1, sleep_pkg::SLEEP_CTRL_OFS, 32'hFFFFFFFF);
    bus(1'b0, sleep_pkg::SLEEP_CTRL_OFS, 32'h0);
    chk("ctrl mask", 32'h0F, rd);
    bus(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h0, rd);
    do_sleep(sleep_pkg::MODE_IDLE, 1'b0, 1'b1);
    chk("unarmed", 32'h0, hold);
    chk("unarmed enables", 32'h1F, en);
    do_sleep(sleep_pkg::MODE_STANDBY, 1'b1, 1'b0);
    chk("standby no crystal", 32'h0, hold);
    for (int i = 0; i < 16; i++) begin
      m = i[2:0];
      do_sleep(m, 1'b1, 1'b1);
      chk("asleep", m inside {3'h0, 3'h1, 3'h2, 3'h6}, hold);
      if (hold === 1'b1) begin
        chk("enables", ens(m), en);
        bus(1'b0, sleep_pkg::SLEEP_STAT_OFS, 32'h0);
        chk("status asleep", 32'h1, rd);
        // a source outside the mode's wake set must not end the sleep
        if (m != 3'h0) begin
          poke(m == 3'h1 ? 7'h20 : 7'h04);
          repeat (12) @(posedge clk_i);
          #1;
          chk("ignored source", 32'h1, hold);
        end
        if (m == 3'h0) poke(7'h40);
        else if (m == 3'h1) poke(7'h01 << $urandom_range(0, 3));
        else poke($urandom_range(0, 1) ? 7'h01 : 7'h10);
        pulses = 0;
        for (n = 1; n < 300; n++) begin
          @(posedge clk_i);
          #1;
          if (resume === 1'b1) pulses++;
          if (hold !== 1'b1) break;
        end
        chk("wake time", wait_len(m, fuse), n);
        chk("resume pulse", 32'h1, pulses);
        chk("enables up", 32'h1F, en);
        if (n == 300) conclude();
        // control contents survive the sleep, then software disarms
        bus(1'b0, sleep_pkg::SLEEP_CTRL_OFS, 32'h0);
        chk("ctrl kept", {28'h0, m, 1'b1}, rd);
        bus(1'b1, sleep_pkg::SLEEP_CTRL_OFS, 32'h0);
      end
    end
    // reset while asleep restarts from the vector
    do_sleep(sleep_pkg::MODE_PDOWN, 1'b1, 1'b1);
    @(posedge clk_i);
    any_reset <= 1'b1;
    #1;
    chk("restart vector", 32'h1, restart_vec);
    @(posedge clk_i);
    any_reset <= 1'b0;
    #1;
    chk("reset wake", 32'h0, hold);
    conclude();
  end
endmodule : sleep_ctrl_test
bind sleep_ctrl sleep_ctrl_props i_sleep_ctrl_props (.clk_i, .srst_i, .any_reset_i,
  .converter_enabled_i, .hreadyout_o, .hresp_o, .hrdata_o, .cpu_hold_o, .resume_irq_o,
  .conv_start_o, .cpu_clock_domain_en_o, .flash_clock_domain_en_o, .io_clock_domain_en_o,
  .converter_clock_domain_en_o, .oscillator_en_o);
`default_nettype wire
